//--- verif/adc_post_conversion_compute_tb_top.sv
// Purpose: self-checking bench of the post-conversion unit
// Assumes: core model answers each start with one done pulse
// Notes:   random results from a fixed seed
`timescale 1ns/1ps
`include "adcpc_cfg.svh"
module adc_post_conversion_compute_tb_top;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  addr = 8'h00;
   logic        rd_r = 1'b0;
   logic        wr_r = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic        trig = 1'b0;
   logic        slow = 1'b0;
   logic [9:0]  val = 10'h000;
   wire  [31:0] rdata;
   wire  [1:0]  rsp_w;
   wire  [9:0]  cres;
   wire         wreq, start, go, dflag, tflag, cdone;
   int          seed = 13881;
   int          error_cnt = 0;
   int          cmp_count = 0;
   logic [31:0] q, a0, c0;
   logic [1:0]  rsp;

   always #25 clk = ~clk;

   adcpc_top adcpc_top_inst (.I_SYS_CLK(clk), .I_RST(rst),
      .I_AVS_ADDRESS(addr), .I_AVS_READ(rd_r), .I_AVS_WRITE(wr_r),
      .I_AVS_WRITEDATA(wdata), .I_AVS_BYTEENABLE(4'hF),
      .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(wreq),
      .O_AVS_RESPONSE(rsp_w), .I_CONV_DONE(cdone), .I_CONV_RESULT(cres),
      .I_TRIGGER(trig), .O_CONV_START(start), .O_GO(go),
      .O_CONV_DONE_FLAG(dflag), .O_THRESH_FLAG(tflag));
   adcpc_core_model adcpc_core_model_inst (.i_clk(clk), .i_start(start),
      .i_slow(slow), .i_value(val), .o_done(cdone), .o_result(cres));

   task automatic end_of_test;
   begin
      $display("compares %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   end
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
   begin
      cmp_count++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   end
   endtask

   task automatic tmo(input int n, input int lim);
   begin
      if (n >= lim)
      begin
         error_cnt++;
         end_of_test();
      end
   end
   endtask

   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
   begin
      n = 0;
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_r <= w;
      rd_r <= !w;
      @(posedge clk);
      while (wreq !== 1'b0 && n < 20)
      begin
         n++;
         @(posedge clk);
      end
      tmo(n, 20);
      q = rdata;
      rsp = rsp_w;
      rd_r <= 1'b0;
      wr_r <= 1'b0;
   end
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
   begin
      bus(1'b0, a, 32'h0);
      chk(q, e);
   end
   endtask

   task automatic nv;
   begin
      @(posedge clk);
      val <= 10'($random(seed));
      slow <= 1'($random(seed));
   end
   endtask

   task automatic wdone(input int k);
      int n;
   begin
      repeat (k)
      begin
         n = 0;
         @(negedge clk);
         while (cdone !== 1'b1 && n < 40)
         begin
            n++;
            @(negedge clk);
         end
         tmo(n, 40);
      end
      repeat (3) @(posedge clk);
   end
   endtask

   task automatic kick(input logic [31:0] c, input int k);
   begin
      bus(1'b1, `ADCPC_OFS_CTRL, c);
      wdone(k);
   end
   endtask

   function automatic logic [31:0] cw(input logic [2:0] m,
      input logic [2:0] c, input logic [1:0] e, input logic [2:0] f);
      cw = {14'h0, e, c, 4'h0, 1'b0, m, f, 2'b11};
   endfunction

   function automatic logic [31:0] errx(input logic [9:0] v,
                                        input logic [9:0] s);
      logic signed [16:0] t;
      t = {7'h00, v} - {7'h00, s};
      errx = {{15{t[16]}}, t};
   endfunction

   initial
   begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      rdc(`ADCPC_OFS_CTRL, `ADCPC_CTRL_RST);
      rdc(`ADCPC_OFS_REPEAT, {24'h0, `ADCPC_REPEAT_RST});
      rdc(8'h30, 32'h0);
      chk({30'h0, rsp}, {30'h0, `ADCPC_RESP_DECERR});
      bus(1'b1, `ADCPC_OFS_RESULT, 32'h155);
      rdc(`ADCPC_OFS_RESULT, 32'h0);
      $display("test registers done");
      nv();
      kick(cw(3'h0, 3'h0, 2'h0, 3'h0), 1);
      a0 = {22'h0, val};
      chk({31'h0, go}, 32'h0);
      chk({31'h0, dflag}, 32'h1);
      rdc(`ADCPC_OFS_ACC, a0);
      nv();
      kick(cw(3'h0, 3'h0, 2'h0, 3'h0), 1);
      rdc(`ADCPC_OFS_PREV, a0);
      rdc(`ADCPC_OFS_RESULT, {22'h0, val});
      $display("test basic done");
      bus(1'b1, `ADCPC_OFS_SETPT, 32'h100);
      bus(1'b1, `ADCPC_OFS_STATUS, 32'h7);
      nv();
      kick(cw(3'h0, 3'h7, 2'h1, 3'h4), 1);
      chk({31'h0, tflag}, 32'h0);
      nv();
      kick(cw(3'h0, 3'h7, 2'h1, 3'h4), 1);
      chk({31'h0, tflag}, 32'h1);
      rdc(`ADCPC_OFS_ERROR, errx(val, 10'h100));
      $display("test double done");
      bus(1'b0, `ADCPC_OFS_ACC, 32'h0);
      a0 = q;
      bus(1'b0, `ADCPC_OFS_COUNT, 32'h0);
      c0 = q;
      for (int i = 0; i < 4; i++)
      begin
         nv();
         kick(cw(3'h1, 3'h0, 2'h0, 3'h0), 1);
         a0 = a0 + val;
      end
      rdc(`ADCPC_OFS_ACC, a0);
      rdc(`ADCPC_OFS_COUNT, c0 + 4);
      $display("test accumulate done");
      bus(1'b1, `ADCPC_OFS_REPEAT, 32'h3);
      nv();
      kick(cw(3'h2, 3'h7, 2'h0, 3'h0), 1);
      bus(1'b1, `ADCPC_OFS_STATUS, 32'h7);
      a0 = 32'h0;
      for (int i = 0; i < 3; i++)
      begin
         nv();
         kick(cw(3'h2, 3'h7, 2'h0, 3'h0), 1);
         a0 = a0 + val;
         if (i == 0)
            chk({31'h0, tflag}, 32'h0);
      end
      chk({31'h0, tflag}, 32'h1);
      rdc(`ADCPC_OFS_ACC, a0);
      $display("test average done");
      bus(1'b1, `ADCPC_OFS_STATUS, 32'h7);
      nv();
      kick(cw(3'h3, 3'h7, 2'h0, 3'h0), 3);
      chk({31'h0, go}, 32'h0);
      chk({31'h0, tflag}, 32'h1);
      rdc(`ADCPC_OFS_ACC, 32'(val) * 3);
      rdc(`ADCPC_OFS_COUNT, 32'h3);
      $display("test burst done");
      bus(1'b1, `ADCPC_OFS_REPEAT, 32'h2);
      bus(1'b1, `ADCPC_OFS_STATUS, 32'h7);
      for (int i = 0; i < 2; i++)
      begin
         nv();
         kick(cw(3'h4, 3'h7, 2'h0, 3'h0), 1);
         rdc(`ADCPC_OFS_FILTER, {22'h0, val});
      end
      chk({31'h0, tflag}, 32'h1);
      $display("test filter done");
      nv();
      kick(cw(3'h0, 3'h0, 2'h0, 3'h1), 2);
      chk({31'h0, go}, 32'h1);
      bus(1'b1, `ADCPC_OFS_CTRL, 32'h1);
      repeat (20) @(posedge clk);
      bus(1'b1, `ADCPC_OFS_STATUS, 32'h7);
      nv();
      trig <= 1'b1;
      wdone(1);
      trig <= 1'b0;
      chk({31'h0, go}, 32'h0);
      chk({31'h0, dflag}, 32'h1);
      rdc(`ADCPC_OFS_RESULT, {22'h0, val});
      $display("test trigger done");
      end_of_test();
   end
endmodule

bind adcpc_top adcpc_chk adcpc_chk_inst (.I_SYS_CLK, .I_RST,
   .I_AVS_ADDRESS, .I_AVS_READ, .I_AVS_WRITE, .O_AVS_READDATA,
   .O_AVS_WAITREQUEST, .O_AVS_RESPONSE, .I_CONV_DONE, .O_CONV_START,
   .O_GO, .O_CONV_DONE_FLAG, .O_THRESH_FLAG);

//--- verif/adcpc_chk.sv
// Purpose: port-level checks of the post-conversion unit
// Assumes: one clock, synchronous reset
// Notes:   busy is rebuilt from start and done
`timescale 1ns/1ps
module adcpc_chk
(
   input wire logic        I_SYS_CLK,
   input wire logic        I_RST,
   input wire logic [7:0]  I_AVS_ADDRESS,
   input wire logic        I_AVS_READ,
   input wire logic        I_AVS_WRITE,
   input wire logic [31:0] O_AVS_READDATA,
   input wire logic        O_AVS_WAITREQUEST,
   input wire logic [1:0]  O_AVS_RESPONSE,
   input wire logic        I_CONV_DONE,
   input wire logic        O_CONV_START,
   input wire logic        O_GO,
   input wire logic        O_CONV_DONE_FLAG,
   input wire logic        O_THRESH_FLAG
);
   logic busy_reg;
   wire  req = I_AVS_READ | I_AVS_WRITE;
   wire  bad = (I_AVS_ADDRESS > 8'h2C) || (I_AVS_ADDRESS[1:0] != 2'h0);

   default clocking cb @(posedge I_SYS_CLK);
   endclocking
   default disable iff (I_RST);

   always_ff @(posedge I_SYS_CLK)
      if (I_RST)
         busy_reg <= 1'b0;
      else if (O_CONV_START)
         busy_reg <= 1'b1;
      else if (I_CONV_DONE)
         busy_reg <= 1'b0;

   bus_ack_a: assert property (req && O_AVS_WAITREQUEST |=>
      !O_AVS_WAITREQUEST) else $error("no ack after request");
   ack_one_a: assert property (!O_AVS_WAITREQUEST |=> O_AVS_WAITREQUEST)
      else $error("ack longer than one cycle");
   idle_zero_a: assert property (O_AVS_WAITREQUEST |->
      O_AVS_READDATA == 32'h0) else $error("read data not zero");
   unmapped_a: assert property (I_AVS_READ && O_AVS_WAITREQUEST && bad
      |=> O_AVS_RESPONSE == 2'h3 && O_AVS_READDATA == 32'h0)
      else $error("unmapped read not refused");
   start_go_a: assert property (O_CONV_START |->
      $past(O_GO) && !busy_reg ##1 !O_CONV_START)
      else $error("start without go or too long");
   done_flag_a: assert property (busy_reg && I_CONV_DONE |=>
      O_CONV_DONE_FLAG) else $error("done flag not set");
   idle_done_a: assert property (!busy_reg && I_CONV_DONE &&
      !O_CONV_DONE_FLAG |=> !O_CONV_DONE_FLAG)
      else $error("done taken while idle");
   thr_cause_a: assert property ($rose(O_THRESH_FLAG) |->
      $past(I_CONV_DONE)) else $error("threshold flag without done");
   busy_hold_a: assert property (busy_reg |-> !O_CONV_START)
      else $error("start while busy");

   cover property (O_CONV_START);
   cover property ($rose(O_THRESH_FLAG));
   cover property (I_AVS_READ && bad && !O_AVS_WAITREQUEST);
endmodule

//--- verif/adcpc_core_model.sv
// Purpose: converter core model answering each start with one result
// Assumes: start is a one-cycle pulse; slow answers take seven cycles
// Notes:   result shows the inverse of the last value outside done
`timescale 1ns/1ps
module adcpc_core_model
(
   input  wire logic       i_clk,
   input  wire logic       i_start,
   input  wire logic       i_slow,
   input  wire logic [9:0] i_value,
   output logic            o_done,
   output logic [9:0]      o_result
);
   int         wait_cnt = 0;
   logic [9:0] last_val = 10'h000;

   initial
   begin
      o_done = 1'b0;
      o_result = 10'h3FF;
   end

   always @(posedge i_clk)
   begin
      o_done <= 1'b0;
      o_result <= ~last_val;
      if (i_start)
         wait_cnt <= i_slow ? 7 : 1;
      else if (wait_cnt == 1)
      begin
         o_done <= 1'b1;
         o_result <= i_value;
         last_val <= i_value;
         wait_cnt <= 0;
      end
      else if (wait_cnt > 1)
         wait_cnt <= wait_cnt - 1;
   end
endmodule

//--- verilog/adcpc_cfg.svh
// Purpose: offsets, reset values and bit positions of the post-conversion unit
// Assumes: byte addresses on a 32-bit Avalon-MM slave
// Notes:   included by the bench and the top module
`ifndef ADCPC_CFG_SVH
`define ADCPC_CFG_SVH

`define ADCPC_OFS_CTRL     8'h00
`define ADCPC_OFS_STATUS   8'h04
`define ADCPC_OFS_RESULT   8'h08
`define ADCPC_OFS_PREV     8'h0C
`define ADCPC_OFS_ACC      8'h10
`define ADCPC_OFS_COUNT    8'h14
`define ADCPC_OFS_REPEAT   8'h18
`define ADCPC_OFS_SETPT    8'h1C
`define ADCPC_OFS_THR_LO   8'h20
`define ADCPC_OFS_THR_HI   8'h24
`define ADCPC_OFS_ERROR    8'h28
`define ADCPC_OFS_FILTER   8'h2C

`define ADCPC_CTRL_RST     32'h0000_0000
`define ADCPC_REPEAT_RST   8'h01
`define ADCPC_GO_BIT       1
`define ADCPC_ST_DONE      0
`define ADCPC_ST_THR       1
`define ADCPC_ST_MATH      2

`define ADCPC_RESP_OK      2'h0
`define ADCPC_RESP_DECERR  2'h3

`endif

//--- verilog/adcpc_pkg.sv
// Purpose: types shared by the post-conversion unit
// Assumes: field layout of the control word is fixed here
// Notes:   reset values and offsets live in adcpc_cfg.svh
package adcpc_pkg;

   typedef enum logic [2:0]
   {
      MODE_BASIC = 3'h0,
      MODE_ACCUM = 3'h1,
      MODE_AVG   = 3'h2,
      MODE_BURST = 3'h3,
      MODE_LPF   = 3'h4
   } adcpc_mode_t;

   // control word, bit 0 is module enable, bit 1 is go
   typedef struct packed
   {
      logic [13:0] rsvd;
      logic [1:0]  err_sel;
      logic [2:0]  cmp_sel;
      logic [3:0]  lpf_shift;
      logic        stop_on_hit;
      adcpc_mode_t mode_select;
      logic        double_sample_enable;
      logic        previous_source_sel;
      logic        continuous_en;
      logic        go;
      logic        enable;
   } adcpc_ctrl_t;

   // finished conversion from the converter core
   typedef struct packed
   {
      logic       done;
      logic [9:0] result;
   } adcpc_conv_t;

endpackage

//--- verilog/adcpc_top.sv
// Purpose: post-conversion computation unit with Avalon-MM registers
// Assumes: converter core on the same clock, trigger pin asynchronous
// Notes:   one register access answered per request, two cycles latency
//
// Functional notes
// R1 - five modes chosen by mode_select
// R2 - results may stop conversions or continue
// R3 - basic mode single or double sample
// R4 - basic sets done flag, threshold by calc
// R5 - accumulate adds result, counts samples
// R6 - average tests after repeat_target samples
// R7 - average clears accumulator on next trigger
// R8 - burst clears, converts repeat_target times, tests
// R9 - filter each result, first test after repeat_target
// R10 - after that, filter and test every trigger
// R11 - old result to previous when select is 0
// R12 - completion clears go, sets flags, updates accumulator; go stays set under continuous_en or mid-burst unless stop_on_hit fires
// R13 - error each or every second conversion
// R14 - filter, error, compare choices are configurable
`timescale 1ns/1ps
`include "adcpc_cfg.svh"

module adcpc_top
   import adcpc_pkg::*;
#(
   parameter int RES_W = 10,
   parameter int ACC_W = 16,
   parameter int CNT_W = 8
)
(
   input  wire logic        I_SYS_CLK,
   input  wire logic        I_RST,
   input  wire logic [7:0]  I_AVS_ADDRESS,
   input  wire logic        I_AVS_READ,
   input  wire logic        I_AVS_WRITE,
   input  wire logic [31:0] I_AVS_WRITEDATA,
   input  wire logic [3:0]  I_AVS_BYTEENABLE,
   output logic      [31:0] O_AVS_READDATA,
   output logic             O_AVS_WAITREQUEST,
   output logic      [1:0]  O_AVS_RESPONSE,
   input  wire logic        I_CONV_DONE,
   input  wire logic [9:0]  I_CONV_RESULT,
   input  wire logic        I_TRIGGER,
   output logic             O_CONV_START,
   output logic             O_GO,
   output logic             O_CONV_DONE_FLAG,
   output logic             O_THRESH_FLAG
);

   // byte-enable merge of a write into a stored word
   function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  be);
      logic [31:0] m;
      m = old_v;
      for (int i = 0; i < 4; i++)
      begin
         if (be[i])
            m[i*8 +: 8] = new_v[i*8 +: 8];
      end
      return m;
   endfunction

   adcpc_ctrl_t        ctrl_reg;
   logic               go_reg;
   logic               busy_reg;
   logic               start_reg;
   logic               burst_reg;
   logic               clr_pend_reg;
   logic               pair_reg;
   logic [2:0]         status_reg;
   logic [RES_W-1:0]   result_reg;
   logic [RES_W-1:0]   previous_result_reg;
   logic [ACC_W-1:0]   accumulator_reg;
   logic [ACC_W-1:0]   filter_reg;
   logic [CNT_W-1:0]   sample_counter;
   logic [CNT_W-1:0]   repeat_target;
   logic [15:0]        setpoint_reg;
   logic [15:0]        thr_lo_reg;
   logic [15:0]        thr_hi_reg;
   logic [16:0]        error_value;
   logic [31:0]        rdata_reg;
   logic [1:0]         resp_reg;
   logic               wait_reg;
   logic [3:0]         trig_sync_reg;
   adcpc_conv_t        conv;

   // bus decode
   wire        req      = I_AVS_READ | I_AVS_WRITE;
   wire        acc_edge = req & ~wait_reg;
   wire        wr_ack   = I_AVS_WRITE & ~wait_reg;
   wire [7:0]  a        = I_AVS_ADDRESS;
   wire        hit_ctrl = a == `ADCPC_OFS_CTRL;
   wire        hit_stat = a == `ADCPC_OFS_STATUS;
   wire        hit_prev = a == `ADCPC_OFS_PREV;
   wire        hit_rpt  = a == `ADCPC_OFS_REPEAT;
   wire        hit_sp   = a == `ADCPC_OFS_SETPT;
   wire        hit_lo   = a == `ADCPC_OFS_THR_LO;
   wire        hit_hi   = a == `ADCPC_OFS_THR_HI;
   wire        mapped   = hit_ctrl | hit_stat | hit_prev | hit_rpt |
                          hit_sp | hit_lo | hit_hi |
                          a == `ADCPC_OFS_RESULT | a == `ADCPC_OFS_ACC |
                          a == `ADCPC_OFS_COUNT | a == `ADCPC_OFS_ERROR |
                          a == `ADCPC_OFS_FILTER;

   wire [31:0] ctrl_rd  = {ctrl_reg[31:2], go_reg, ctrl_reg.enable};
   wire [31:0] rd_mux =
      hit_ctrl ? ctrl_rd :
      hit_stat ? {29'h0, status_reg} :
      a == `ADCPC_OFS_RESULT ? {{(32-RES_W){1'b0}}, result_reg} :
      hit_prev ? {{(32-RES_W){1'b0}}, previous_result_reg} :
      a == `ADCPC_OFS_ACC ? {{(32-ACC_W){1'b0}}, accumulator_reg} :
      a == `ADCPC_OFS_COUNT ? {{(32-CNT_W){1'b0}}, sample_counter} :
      hit_rpt  ? {{(32-CNT_W){1'b0}}, repeat_target} :
      hit_sp   ? {16'h0000, setpoint_reg} :
      hit_lo   ? {16'h0000, thr_lo_reg} :
      hit_hi   ? {16'h0000, thr_hi_reg} :
      a == `ADCPC_OFS_ERROR ? {{15{error_value[16]}}, error_value} :
      a == `ADCPC_OFS_FILTER ? {{(32-ACC_W){1'b0}}, filter_reg} :
      32'h0000_0000;

   wire [31:0] wr_ctrl  = be_merge(ctrl_rd, I_AVS_WRITEDATA,
                                   I_AVS_BYTEENABLE);
   wire [31:0] wr_stat  = be_merge(32'h0000_0000, I_AVS_WRITEDATA,
                                   I_AVS_BYTEENABLE);
   wire [31:0] wr_prev  = be_merge({{(32-RES_W){1'b0}}, previous_result_reg},
                                   I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
   wire [31:0] wr_rpt   = be_merge({{(32-CNT_W){1'b0}}, repeat_target},
                                   I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
   wire [31:0] wr_sp    = be_merge({16'h0000, setpoint_reg},
                                   I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
   wire [31:0] wr_lo    = be_merge({16'h0000, thr_lo_reg},
                                   I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
   wire [31:0] wr_hi    = be_merge({16'h0000, thr_hi_reg},
                                   I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
   wire        ctrl_wr  = wr_ack & hit_ctrl;

   // trigger pin edge, taken once second and third stage agree
   wire        trig_rise = (&trig_sync_reg[2:1]) & ~trig_sync_reg[3];
   wire        trig_hold = trig_rise |
                           (trig_sync_reg[3] & (|trig_sync_reg[2:1]));

   // conversion start and completion
   assign conv = {I_CONV_DONE & busy_reg, I_CONV_RESULT};
   wire        start_ok = ctrl_reg.enable & go_reg & ~busy_reg & ~start_reg;
   adcpc_mode_t mode;
   assign mode = ctrl_reg.mode_select;                                  // [R1]
   wire        is_accum = mode == MODE_ACCUM;
   wire        is_avg   = mode == MODE_AVG;
   wire        is_burst = mode == MODE_BURST;
   wire        is_lpf   = mode == MODE_LPF;
   wire        is_basic = ~(is_accum | is_avg | is_burst | is_lpf);
   wire        burst_go = start_ok & is_burst & ~burst_reg;             // [R8]

   // accumulator and counter next values
   wire [ACC_W-1:0] d_ext   = {{(ACC_W-RES_W){1'b0}}, conv.result};
   wire [ACC_W-1:0] acc_base = (is_avg & clr_pend_reg) ?
                               {ACC_W{1'b0}} : accumulator_reg;         // [R7]
   wire [CNT_W-1:0] cnt_base = (is_avg & clr_pend_reg) ?
                               {CNT_W{1'b0}} : sample_counter;
   wire [ACC_W-1:0] acc_sum = acc_base + d_ext;                         // [R5]
   wire             cnt_max = &cnt_base;
   wire [CNT_W-1:0] cnt_inc = cnt_max ? cnt_base :
                              cnt_base + {{(CNT_W-1){1'b0}}, 1'b1};
   wire [ACC_W-1:0] acc_new = is_basic ? d_ext : acc_sum;               // [R12]

   // low-pass filter, coefficient is a power-of-two shift
   wire signed [ACC_W:0] lpf_diff = $signed({1'b0, d_ext}) -
                                    $signed({1'b0, filter_reg});
   wire signed [ACC_W:0] lpf_step = lpf_diff >>> ctrl_reg.lpf_shift;    // [R14]
   wire [ACC_W-1:0] lpf_new = filter_reg + lpf_step[ACC_W-1:0];         // [R9]
   wire [ACC_W-1:0] avg_new = acc_new >> ctrl_reg.lpf_shift;
   wire [ACC_W-1:0] calc_v  = is_lpf ? lpf_new : avg_new;

   // test cadence per mode
   wire reached   = cnt_inc >= repeat_target;
   wire pair_ok   = ~ctrl_reg.double_sample_enable | pair_reg;          // [R3]
   wire test_now  = (is_basic | is_accum) ? pair_ok :                   // [R13]
                    reached;                                    // [R6] [R10]

   // error calculation variants
   wire signed [16:0] sp_s  = $signed({1'b0, setpoint_reg});
   wire signed [16:0] res_s = $signed({{(17-RES_W){1'b0}}, conv.result});
   wire signed [16:0] old_s = $signed({{(17-RES_W){1'b0}}, result_reg});
   wire signed [16:0] prv_s =
      $signed({{(17-RES_W){1'b0}}, previous_result_reg});
   wire signed [16:0] clc_s = $signed({1'b0, calc_v[15:0]});
   wire signed [16:0] err_new =
      ctrl_reg.err_sel == 2'h0 ? res_s - old_s :
      ctrl_reg.err_sel == 2'h1 ? res_s - sp_s  :
      ctrl_reg.err_sel == 2'h2 ? clc_s - sp_s  :
      prv_s - sp_s;                                                     // [R14]
   wire signed [16:0] lo_s = $signed({thr_lo_reg[15], thr_lo_reg});
   wire signed [16:0] hi_s = $signed({thr_hi_reg[15], thr_hi_reg});
   wire below = err_new < lo_s;
   wire above = err_new > hi_s;
   wire cmp_hit =
      ctrl_reg.cmp_sel == 3'h1 ? below :
      ctrl_reg.cmp_sel == 3'h2 ? ~below :
      ctrl_reg.cmp_sel == 3'h3 ? above :
      ctrl_reg.cmp_sel == 3'h4 ? ~above :
      ctrl_reg.cmp_sel == 3'h5 ? below | above :
      ctrl_reg.cmp_sel == 3'h6 ? ~(below | above) :
      ctrl_reg.cmp_sel == 3'h7;
   wire thr_set  = conv.done & test_now & cmp_hit;                      // [R4]

   // go after completion: repeat or stop
   wire keep_on  = ctrl_reg.continuous_en | (is_burst & ~test_now);    // [R8]
   wire stop_hit = ctrl_reg.stop_on_hit & thr_set;                      // [R2]
   wire go_clr   = conv.done & (~keep_on | stop_hit);                   // [R12]
   wire go_hw    = trig_rise ? 1'b1 : (go_clr ? 1'b0 : go_reg);
   wire go_next  = ctrl_wr ? wr_ctrl[`ADCPC_GO_BIT] : go_hw;

   // sticky flags, hardware set wins over software clear
   wire [2:0] st_set = {conv.done, thr_set, conv.done};
   wire [2:0] st_clr = (wr_ack & hit_stat) ? wr_stat[2:0] : 3'h0;
   wire [2:0] status_next = st_set | (status_reg & ~st_clr);

   // bus slave
   always_ff @(posedge I_SYS_CLK)
   begin
      if (I_RST)
      begin
         wait_reg  <= 1'b1;
         rdata_reg <= 32'h0000_0000;
         resp_reg  <= `ADCPC_RESP_OK;
      end
      else
      begin
         wait_reg  <= ~(req & wait_reg);
         rdata_reg <= (I_AVS_READ & wait_reg) ? rd_mux : 32'h0000_0000;
         resp_reg  <= (req & wait_reg & ~mapped) ?
                      `ADCPC_RESP_DECERR : `ADCPC_RESP_OK;
      end
   end

   // software-written settings
   always_ff @(posedge I_SYS_CLK)
   begin
      if (I_RST)
      begin
         ctrl_reg      <= `ADCPC_CTRL_RST;
         repeat_target <= CNT_W'(`ADCPC_REPEAT_RST);
         setpoint_reg  <= 16'h0000;
         thr_lo_reg    <= 16'h0000;
         thr_hi_reg    <= 16'h0000;
      end
      else
      begin
         if (ctrl_wr)
            ctrl_reg <= {14'h0000, wr_ctrl[17:2], 1'b0, wr_ctrl[0]};
         if (wr_ack & hit_rpt)
            repeat_target <= wr_rpt[CNT_W-1:0];
         if (wr_ack & hit_sp)
            setpoint_reg <= wr_sp[15:0];
         if (wr_ack & hit_lo)
            thr_lo_reg <= wr_lo[15:0];
         if (wr_ack & hit_hi)
            thr_hi_reg <= wr_hi[15:0];
      end
   end

   // conversion sequencing
   always_ff @(posedge I_SYS_CLK)
   begin
      if (I_RST)
      begin
         trig_sync_reg <= 4'h0;
         go_reg        <= 1'b0;
         start_reg     <= 1'b0;
         busy_reg      <= 1'b0;
         burst_reg     <= 1'b0;
         status_reg    <= 3'h0;
      end
      else
      begin
         trig_sync_reg <= {trig_hold, trig_sync_reg[1:0], I_TRIGGER};
         go_reg        <= go_next;
         start_reg     <= start_ok;
         busy_reg      <= start_ok | (busy_reg & ~conv.done);
         status_reg    <= status_next;                                  // [R4]
         if (burst_go)
            burst_reg <= 1'b1;
         else if (conv.done & (test_now | ~is_burst))
            burst_reg <= 1'b0;
      end
   end

   // result path and computation
   always_ff @(posedge I_SYS_CLK)
   begin
      if (I_RST)
      begin
         result_reg          <= {RES_W{1'b0}};
         previous_result_reg <= {RES_W{1'b0}};
         accumulator_reg     <= {ACC_W{1'b0}};
         filter_reg          <= {ACC_W{1'b0}};
         sample_counter      <= {CNT_W{1'b0}};
         error_value         <= 17'h00000;
         clr_pend_reg        <= 1'b0;
         pair_reg            <= 1'b0;
      end
      else if (burst_go)
      begin
         accumulator_reg <= {ACC_W{1'b0}};                              // [R8]
         sample_counter  <= {CNT_W{1'b0}};
      end
      else if (conv.done)
      begin
         if (!ctrl_reg.previous_source_sel)
            previous_result_reg <= result_reg;                          // [R11]
         result_reg      <= conv.result;
         accumulator_reg <= acc_new;                                    // [R12]
         filter_reg      <= lpf_new;                                    // [R9]
         if (!is_basic)
            sample_counter <= cnt_inc;                                  // [R5]
         pair_reg     <= ctrl_reg.double_sample_enable & ~pair_reg;     // [R3]
         clr_pend_reg <= is_avg & test_now;                             // [R7]
         if (test_now)
            error_value <= err_new;                                     // [R13]
      end
      else
      begin
         if (wr_ack & hit_prev & ctrl_reg.previous_source_sel)
            previous_result_reg <= wr_prev[RES_W-1:0];
         if (!ctrl_reg.double_sample_enable)
            pair_reg <= 1'b0;
      end
   end

   assign O_AVS_READDATA    = rdata_reg;
   assign O_AVS_WAITREQUEST = wait_reg;
   assign O_AVS_RESPONSE    = resp_reg;
   assign O_CONV_START      = start_reg;
   assign O_GO              = go_reg;
   assign O_CONV_DONE_FLAG  = status_reg[`ADCPC_ST_DONE];
   assign O_THRESH_FLAG     = status_reg[`ADCPC_ST_THR];

endmodule
